// ---- shared/sysmon_pkg.sv ----
// Constants shared by the system monitor converter control block
package sysmon_pkg;
  // ==========================================================================
  // Widths and channel plan
  localparam int REG_AW      = 7;
  localparam int DW          = 16;
  localparam int WB_DW       = 32;
  localparam int WB_AW       = 32;
  localparam int WB_ADR_LSB  = 2;
  localparam int SAMPLE_W    = 12;
  localparam int NUM_AUX     = 16;
  localparam int NUM_SENSORS = 3;
  localparam int NUM_CH      = NUM_SENSORS + 1 + NUM_AUX;
  localparam int CH_W        = 5;
  localparam int CH_TEMP     = 0;
  localparam int CH_AUX0     = 4;
  localparam int RESULT_LSB  = DW - SAMPLE_W;
  localparam int AVG_MAX_LOG = 8;
  localparam int ACC_W       = SAMPLE_W + AVG_MAX_LOG;
  localparam int CNT_W       = AVG_MAX_LOG + 1;
  // ==========================================================================
  // Register indices (byte address on the bus is four times the index)
  localparam logic [REG_AW-1:0] REG_RESULT0    = 7'h00;
  localparam logic [REG_AW-1:0] REG_MAX0       = 7'h20;
  localparam logic [REG_AW-1:0] REG_MIN0       = 7'h24;
  localparam logic [REG_AW-1:0] REG_CTRL_BASE  = 7'h40;
  localparam logic [REG_AW-1:0] REG_CFG        = 7'h40;
  localparam logic [REG_AW-1:0] REG_CHSEL_LO   = 7'h41;
  localparam logic [REG_AW-1:0] REG_CHSEL_HI   = 7'h42;
  localparam logic [REG_AW-1:0] REG_BIP_LO     = 7'h43;
  localparam logic [REG_AW-1:0] REG_BIP_HI     = 7'h44;
  localparam logic [REG_AW-1:0] REG_UPPER0     = 7'h50;
  localparam logic [REG_AW-1:0] REG_OT_TRIP    = 7'h53;
  localparam logic [REG_AW-1:0] REG_LOWER0     = 7'h54;
  localparam logic [REG_AW-1:0] REG_OT_RELEASE = 7'h57;
  localparam logic [REG_AW-1:0] REG_INT_STATUS = 7'h60;
  localparam logic [REG_AW-1:0] REG_INT_MASK   = 7'h61;
  localparam logic [REG_AW-1:0] REG_FLAGS      = 7'h62;
  // ==========================================================================
  // Field positions
  localparam int CFG_SEQ_EN  = 0;
  localparam int CFG_AVG_LSB = 1;
  localparam int CFG_AUTOPD  = 3;
  localparam int INT_EOC     = 0;
  localparam int INT_EOS     = 1;
  localparam int INT_ALARM   = 2;
  localparam int INT_OT      = 3;
  localparam int INT_W       = 4;
  localparam int FLAG_OT     = 3;
  localparam int FLAG_HOLD   = 4;
  localparam int FLAG_BUSY   = 5;
  localparam int FLAG_DEFMODE = 6;
  localparam int HI_W        = NUM_CH - DW;
  // ==========================================================================
  // Averaging encodings and reset values
  localparam logic [1:0]  AVG_NONE = 2'h0;
  localparam logic [1:0]  AVG_16   = 2'h1;
  localparam logic [1:0]  AVG_64   = 2'h2;
  localparam logic [3:0]  SHIFT_16 = 4'h4;
  localparam logic [3:0]  SHIFT_64 = 4'h6;
  localparam logic [3:0]  SHIFT_256 = 4'h8;
  localparam logic [NUM_CH-1:0] DEFAULT_CHSEL = 20'h00007;
  localparam logic [DW-1:0] MAX_RESET = 16'h0000;
  localparam logic [DW-1:0] MIN_RESET = 16'hFFFF;
  // ==========================================================================
  // Timing of the shutdown and start-up sequences
  localparam int CLK_MHZ      = 250;
  localparam int SHUTDOWN_NS  = 1000;
  localparam int STARTUP_NS   = 1000;
  localparam int SHUTDOWN_CYC = (SHUTDOWN_NS * CLK_MHZ + 999) / 1000;
  localparam int STARTUP_CYC  = (STARTUP_NS * CLK_MHZ + 999) / 1000;
  localparam int SEQ_CNT_W    = 12;
endpackage : sysmon_pkg

// ---- design/sysmon_ctrl.sv ----
// System monitor converter control: sequencing, averaging, results, alarms, bus ports
`timescale 1ns/10ps
// How it works
// RQ1 - Sequencer converts enabled channels, stores every result
// RQ2 - Optional averaging over 16, 64 or 256 samples
// RQ3 - Supply and temperature alarms outside configured range
// RQ4 - 16-bit synchronous reconfiguration port reaches all registers
// RQ5 - Test access read path returns conversion results
// RQ6 - Without user instance, default mode monitors sensors
// RQ7 - Control registers start from attributes, writable after configuration
// RQ8 - Read-only results; sensor min and max tracked
// RQ9 - Conversion done and sequence done strobes
// RQ10 - Over-temperature at factory limit or user threshold
// RQ11 - Over-temperature release below lower limit, hysteresis
// RQ12 - Auto power-down: shutdown sequence, assert output hold
// RQ13 - Alarm clear: release hold, run start-up sequence
// RQ14 - Twelve-bit samples from converter, one per conversion
// RQ15 - Dedicated pair plus sixteen auxiliary channels addressable
// RQ16 - Per-channel unipolar or bipolar result encoding
// RQ17 - Enable strobe in, one-cycle ready with data
module sysmon_ctrl #(
  parameter logic [sysmon_pkg::DW-1:0]     CFG_INIT        = 16'h0001,
  parameter logic [sysmon_pkg::NUM_CH-1:0] CHSEL_INIT      = 20'h0000F,
  parameter logic [sysmon_pkg::NUM_CH-1:0] BIPOLAR_INIT    = 20'h00000,
  parameter logic [sysmon_pkg::DW-1:0]     UPPER_INIT      = 16'hFFF0,
  parameter logic [sysmon_pkg::DW-1:0]     LOWER_INIT      = 16'h0000,
  parameter logic [sysmon_pkg::DW-1:0]     OT_TRIP_INIT    = 16'hFFF0,
  parameter logic [sysmon_pkg::DW-1:0]     OT_RELEASE_INIT = 16'h0000,
  parameter logic [sysmon_pkg::DW-1:0]     TEMP_TRIP_CODE  = 16'hC000,
  parameter logic [sysmon_pkg::DW-1:0]     TEMP_REL_CODE   = 16'h9000,
  parameter int                            SHUTDOWN_CYCLES = sysmon_pkg::SHUTDOWN_CYC,
  parameter int                            STARTUP_CYCLES  = sysmon_pkg::STARTUP_CYC
) (
  // Clock and reset
  input  wire logic                              i_mclk,
  input  wire logic                              i_rst,
  // Device state
  input  wire logic                              i_config_done,
  input  wire logic                              i_block_used,
  // Wishbone slave
  input  wire logic                              i_wb_cyc,
  input  wire logic                              i_wb_stb,
  input  wire logic                              i_wb_we,
  input  wire logic [sysmon_pkg::WB_AW-1:0]      i_wb_adr,
  input  wire logic [sysmon_pkg::WB_DW/8-1:0]    i_wb_sel,
  input  wire logic [sysmon_pkg::WB_DW-1:0]      i_wb_dat,
  output logic      [sysmon_pkg::WB_DW-1:0]      o_wb_dat,
  output logic                                   o_wb_ack,
  // Dynamic reconfiguration port
  input  wire logic                              i_drp_en,
  input  wire logic                              i_drp_we,
  input  wire logic [sysmon_pkg::REG_AW-1:0]     i_drp_addr,
  input  wire logic [sysmon_pkg::DW-1:0]         i_drp_di,
  output logic      [sysmon_pkg::DW-1:0]         o_drp_do,
  output logic                                   o_drp_rdy,
  // Test access read path
  input  wire logic                              i_jtag_rd_en,
  input  wire logic [sysmon_pkg::REG_AW-1:0]     i_jtag_addr,
  output logic      [sysmon_pkg::DW-1:0]         o_jtag_data,
  output logic                                   o_jtag_rdy,
  // Converter core
  output logic                                   o_conv_start,
  output logic      [sysmon_pkg::CH_W-1:0]       o_conv_chan,
  input  wire logic                              i_conv_valid,
  input  wire logic [sysmon_pkg::SAMPLE_W-1:0]   i_conv_data,
  // Events and alarms
  output logic                                   o_conversion_done,
  output logic                                   o_sequence_done,
  output logic      [sysmon_pkg::NUM_SENSORS-1:0] o_alarm,
  output logic                                   o_overtemp_alarm,
  output logic                                   o_cfg_shutdown,
  output logic                                   o_global_output_hold,
  output logic                                   o_startup_active,
  output logic                                   o_irq
);
  import sysmon_pkg::*;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_START, SEQ_WAIT} sysmon_seq_e;
  typedef enum logic [1:0] {PD_RUN, PD_SHUTDOWN, PD_HOLD, PD_STARTUP} sysmon_pd_e;

  // ==========================================================================
  // State
  logic [DW-1:0]          result_mem [NUM_CH];
  logic [DW-1:0]          max_val    [NUM_SENSORS];
  logic [DW-1:0]          min_val    [NUM_SENSORS];
  logic [DW-1:0]          upper      [NUM_SENSORS];
  logic [DW-1:0]          lower      [NUM_SENSORS];
  logic [DW-1:0]          cfg;
  logic [NUM_CH-1:0]      chsel;
  logic [NUM_CH-1:0]      bipolar;
  logic [DW-1:0]          ot_trip;
  logic [DW-1:0]          ot_release;
  logic [INT_W-1:0]       int_status;
  logic [INT_W-1:0]       int_mask;
  sysmon_seq_e            seq_state;
  sysmon_pd_e             pd_state;
  logic [CH_W-1:0]        chan;
  logic [ACC_W-1:0]       acc;
  logic [CNT_W-1:0]       avg_cnt;
  logic [SEQ_CNT_W-1:0]   pd_cnt;

  // ==========================================================================
  // Functions
  function automatic logic [CH_W-1:0] next_chan(input logic [CH_W-1:0]   cur,
                                                input logic [NUM_CH-1:0] set);
    logic [CH_W-1:0] nxt;
    logic            found;
    int              c;
    nxt   = cur;
    found = 1'b0;
    for (int k = 1; k <= NUM_CH; k++) begin
      c = (int'(cur) + k) % NUM_CH;
      if (!found && set[c]) begin
        nxt   = CH_W'(c);
        found = 1'b1;
      end
    end
    return nxt;
  endfunction : next_chan

  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old_v,
                                          input logic [DW-1:0] new_v,
                                          input logic [1:0]    be);
    return {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
  endfunction : merge

  function automatic logic [DW-1:0] reg_read(input logic [REG_AW-1:0] idx);
    logic [DW-1:0] v;
    v = '0;
    if (idx < REG_AW'(NUM_CH)) begin
      v = result_mem[idx[CH_W-1:0]];
    end
    for (int s = 0; s < NUM_SENSORS; s++) begin
      if (idx == REG_MAX0 + REG_AW'(s)) v = max_val[s];
      if (idx == REG_MIN0 + REG_AW'(s)) v = min_val[s];
      if (idx == REG_UPPER0 + REG_AW'(s)) v = upper[s];
      if (idx == REG_LOWER0 + REG_AW'(s)) v = lower[s];
    end
    unique case (idx)
      REG_CFG:        v = cfg;
      REG_CHSEL_LO:   v = chsel[DW-1:0];
      REG_CHSEL_HI:   v = {{(DW-HI_W){1'b0}}, chsel[NUM_CH-1:DW]};
      REG_BIP_LO:     v = bipolar[DW-1:0];
      REG_BIP_HI:     v = {{(DW-HI_W){1'b0}}, bipolar[NUM_CH-1:DW]};
      REG_OT_TRIP:    v = ot_trip;
      REG_OT_RELEASE: v = ot_release;
      REG_INT_STATUS: v = {{(DW-INT_W){1'b0}}, int_status};
      REG_INT_MASK:   v = {{(DW-INT_W){1'b0}}, int_mask};
      REG_FLAGS: begin
        v[NUM_SENSORS-1:0] = o_alarm;
        v[FLAG_OT]         = o_overtemp_alarm;
        v[FLAG_HOLD]       = o_global_output_hold;
        v[FLAG_BUSY]       = (seq_state != SEQ_IDLE);
        v[FLAG_DEFMODE]    = !i_block_used;
      end
      default: ;
    endcase
    return v;
  endfunction : reg_read

  // ==========================================================================
  // Register access decode
  logic              wb_req;
  logic [REG_AW-1:0] wb_idx;
  logic              wr_en;
  logic [REG_AW-1:0] wr_idx;
  logic [DW-1:0]     wr_data;
  logic [1:0]        wr_be;

  assign wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign wb_idx = i_wb_adr[REG_AW+WB_ADR_LSB-1:WB_ADR_LSB];

  // Bus write wins a same-cycle collision with the port; attributes hold until done
  always_comb begin
    wr_idx  = wb_req && i_wb_we ? wb_idx : i_drp_addr;
    wr_data = wb_req && i_wb_we ? i_wb_dat[DW-1:0] : i_drp_di;
    wr_be   = wb_req && i_wb_we ? i_wb_sel[1:0] : 2'h3;
    wr_en   = ((wb_req && i_wb_we) || (i_drp_en && i_drp_we))
              && i_config_done && i_block_used; // RQ7 RQ4
  end

  // ==========================================================================
  // Control registers
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cfg        <= CFG_INIT; // RQ7
      chsel      <= CHSEL_INIT;
      bipolar    <= BIPOLAR_INIT;
      ot_trip    <= OT_TRIP_INIT;
      ot_release <= OT_RELEASE_INIT;
      int_mask   <= '0;
      for (int s = 0; s < NUM_SENSORS; s++) begin
        upper[s] <= UPPER_INIT;
        lower[s] <= LOWER_INIT;
      end
    end else if (wr_en && wr_idx >= REG_CTRL_BASE) begin // RQ8
      unique case (wr_idx)
        REG_CFG:        cfg <= merge(cfg, wr_data, wr_be);
        REG_CHSEL_LO:   chsel[DW-1:0] <= merge(chsel[DW-1:0], wr_data, wr_be); // RQ15
        REG_CHSEL_HI:   chsel[NUM_CH-1:DW] <= wr_be[0] ? wr_data[HI_W-1:0] : chsel[NUM_CH-1:DW];
        REG_BIP_LO:     bipolar[DW-1:0] <= merge(bipolar[DW-1:0], wr_data, wr_be);
        REG_BIP_HI:     bipolar[NUM_CH-1:DW] <= wr_be[0] ? wr_data[HI_W-1:0]
                                                          : bipolar[NUM_CH-1:DW];
        REG_OT_TRIP:    ot_trip <= merge(ot_trip, wr_data, wr_be);
        REG_OT_RELEASE: ot_release <= merge(ot_release, wr_data, wr_be);
        REG_INT_MASK:   int_mask <= wr_be[0] ? wr_data[INT_W-1:0] : int_mask;
        default: begin
          for (int s = 0; s < NUM_SENSORS; s++) begin
            if (wr_idx == REG_UPPER0 + REG_AW'(s)) upper[s] <= merge(upper[s], wr_data, wr_be);
            if (wr_idx == REG_LOWER0 + REG_AW'(s)) lower[s] <= merge(lower[s], wr_data, wr_be);
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Effective mode: default mode ignores the sequence-enable, channel-select and averaging settings
  logic              seq_on;
  logic [NUM_CH-1:0] active_set;
  logic [3:0]        avg_shift;
  logic [CNT_W-1:0]  avg_target;

  always_comb begin
    seq_on     = i_block_used ? cfg[CFG_SEQ_EN] : 1'b1; // RQ6
    active_set = i_block_used ? chsel : DEFAULT_CHSEL; // RQ6
    unique case (i_block_used ? cfg[CFG_AVG_LSB +: 2] : AVG_NONE) // RQ2
      AVG_NONE: avg_shift = 4'h0;
      AVG_16:   avg_shift = SHIFT_16;
      AVG_64:   avg_shift = SHIFT_64;
      default:  avg_shift = SHIFT_256;
    endcase
    avg_target = CNT_W'(1) << avg_shift;
  end

  // ==========================================================================
  // Sequencer and averaging
  logic [CH_W-1:0]     chan_next;
  logic                sample_last;
  logic [ACC_W-1:0]    acc_sum;
  logic [SAMPLE_W-1:0] avg_code;
  logic [DW-1:0]       result;
  logic                finish;

  always_comb begin
    chan_next   = next_chan(chan, active_set);
    acc_sum     = acc + ACC_W'(i_conv_data); // RQ14
    avg_code    = SAMPLE_W'(acc_sum >> avg_shift); // RQ2
    // Offset binary from the core becomes two's complement for bipolar inputs
    if (bipolar[chan] && i_block_used && chan >= CH_W'(CH_AUX0 - 1)) begin
      avg_code[SAMPLE_W-1] = ~avg_code[SAMPLE_W-1]; // RQ16
    end
    result      = {avg_code, {RESULT_LSB{1'b0}}};
    sample_last = (avg_cnt + CNT_W'(1)) == avg_target;
    finish      = (seq_state == SEQ_WAIT) && i_conv_valid && sample_last;
  end

  assign o_conv_start = (seq_state == SEQ_START); // RQ1

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      seq_state   <= SEQ_IDLE;
      chan        <= '0;
      acc         <= '0;
      avg_cnt     <= '0;
      o_conv_chan <= '0;
    end else begin
      unique case (seq_state)
        SEQ_IDLE: begin
          if (seq_on && active_set != '0) begin
            chan        <= next_chan(CH_W'(NUM_CH - 1), active_set); // RQ1
            o_conv_chan <= next_chan(CH_W'(NUM_CH - 1), active_set);
            seq_state   <= SEQ_START;
          end
        end
        SEQ_START: seq_state <= SEQ_WAIT;
        SEQ_WAIT: begin
          if (i_conv_valid) begin
            if (sample_last) begin
              acc     <= '0;
              avg_cnt <= '0;
              chan        <= chan_next; // RQ1
              o_conv_chan <= chan_next;
              seq_state   <= (seq_on && active_set != '0) ? SEQ_START : SEQ_IDLE;
            end else begin
              acc       <= acc_sum; // RQ2
              avg_cnt   <= avg_cnt + CNT_W'(1);
              seq_state <= SEQ_START;
            end
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Result storage, min and max, strobes
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      for (int c = 0; c < NUM_CH; c++) result_mem[c] <= '0;
      for (int s = 0; s < NUM_SENSORS; s++) begin
        max_val[s] <= MAX_RESET; // RQ8
        min_val[s] <= MIN_RESET;
      end
      o_conversion_done <= 1'b0;
      o_sequence_done   <= 1'b0;
    end else begin
      o_conversion_done <= finish; // RQ9
      o_sequence_done   <= finish && (chan_next <= chan); // RQ9
      if (finish) begin
        result_mem[chan] <= result; // RQ1
        if (chan < CH_W'(NUM_SENSORS)) begin
          if (result > max_val[chan[1:0]]) max_val[chan[1:0]] <= result; // RQ8
          if (result < min_val[chan[1:0]]) min_val[chan[1:0]] <= result; // RQ8
        end
      end
    end
  end

  // ==========================================================================
  // Range alarms and over-temperature with hysteresis
  logic temp_done;
  logic ot_rise;

  assign temp_done = finish && chan == CH_W'(CH_TEMP);
  assign ot_rise   = temp_done && !o_overtemp_alarm
                     && (result >= TEMP_TRIP_CODE || result >= ot_trip);

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_alarm          <= '0;
      o_overtemp_alarm <= 1'b0;
    end else begin
      if (finish && chan < CH_W'(NUM_SENSORS)) begin
        o_alarm[chan[1:0]] <= (result > upper[chan[1:0]])
                              || (result < lower[chan[1:0]]); // RQ3
      end
      if (ot_rise) begin
        o_overtemp_alarm <= 1'b1; // RQ10
      end else if (temp_done && (result < TEMP_REL_CODE || result < ot_release)) begin
        o_overtemp_alarm <= 1'b0; // RQ11
      end
    end
  end

  // ==========================================================================
  // Automatic power-down; temperature is still sampled while held
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      pd_state <= PD_RUN;
      pd_cnt   <= '0;
    end else begin
      unique case (pd_state)
        PD_RUN: begin
          if (ot_rise && cfg[CFG_AUTOPD]) begin
            pd_state <= PD_SHUTDOWN; // RQ12
            pd_cnt   <= '0;
          end
        end
        PD_SHUTDOWN: begin
          pd_cnt <= pd_cnt + SEQ_CNT_W'(1);
          if (pd_cnt == SEQ_CNT_W'(SHUTDOWN_CYCLES - 1)) pd_state <= PD_HOLD;
        end
        PD_HOLD: begin
          if (!o_overtemp_alarm) begin
            pd_state <= PD_STARTUP; // RQ13
            pd_cnt   <= '0;
          end
        end
        PD_STARTUP: begin
          pd_cnt <= pd_cnt + SEQ_CNT_W'(1);
          if (pd_cnt == SEQ_CNT_W'(STARTUP_CYCLES - 1)) pd_state <= PD_RUN;
        end
      endcase
    end
  end

  assign o_cfg_shutdown       = (pd_state == PD_SHUTDOWN); // RQ12
  assign o_global_output_hold = (pd_state == PD_SHUTDOWN) || (pd_state == PD_HOLD); // RQ12
  assign o_startup_active     = (pd_state == PD_STARTUP); // RQ13

  // ==========================================================================
  // Interrupts: set beats a same-cycle write-one clear
  logic [INT_W-1:0] int_event;
  logic [INT_W-1:0] int_clear;

  always_comb begin
    int_event            = '0;
    int_event[INT_EOC]   = o_conversion_done;
    int_event[INT_EOS]   = o_sequence_done;
    int_event[INT_ALARM] = finish && chan < CH_W'(NUM_SENSORS) && !o_alarm[chan[1:0]]
                           && ((result > upper[chan[1:0]]) || (result < lower[chan[1:0]]));
    int_event[INT_OT]    = ot_rise;
    int_clear = (wr_en && wr_idx == REG_INT_STATUS && wr_be[0]) ? wr_data[INT_W-1:0] : '0;
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      int_status <= '0;
    end else begin
      int_status <= (int_status & ~int_clear) | int_event;
    end
  end

  assign o_irq = |(int_status & int_mask);

  // ==========================================================================
  // Read answers: bus, reconfiguration port, test access path
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_wb_ack    <= 1'b0;
      o_wb_dat    <= '0;
      o_drp_rdy   <= 1'b0;
      o_drp_do    <= '0;
      o_jtag_rdy  <= 1'b0;
      o_jtag_data <= '0;
    end else begin
      o_wb_ack <= wb_req;
      if (wb_req && !i_wb_we) begin
        o_wb_dat <= (i_wb_adr[WB_AW-1:REG_AW+WB_ADR_LSB] == '0)
                    ? {{(WB_DW-DW){1'b0}}, reg_read(wb_idx)} : '0;
      end
      o_drp_rdy <= i_drp_en; // RQ17
      if (i_drp_en && !i_drp_we) o_drp_do <= reg_read(i_drp_addr); // RQ4
      o_jtag_rdy <= i_jtag_rd_en;
      if (i_jtag_rd_en) o_jtag_data <= reg_read(i_jtag_addr); // RQ5
    end
  end

endmodule : sysmon_ctrl

// ---- verification/sysmon_conv_model.sv ----
// Converter core model: answers each start after seven cycles
`timescale 1ns/10ps
module sysmon_conv_model (
  input  wire logic        i_mclk, i_rst, i_start,
  input  wire logic [4:0]  i_chan,
  input  wire logic [11:0] i_temp,
  output logic             o_valid,
  output logic [11:0]      o_data
);
  logic [2:0] cnt;
  // Data toggles outside the valid cycle so a stale sample never passes
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      {cnt, o_valid, o_data} <= 16'h0000;
    end else begin
      o_valid <= (cnt == 3'h1);
      o_data <= (cnt != 3'h1) ? ~o_data : (i_chan == 5'h00) ? i_temp : 12'h200 + 12'(i_chan);
      cnt <= i_start ? 3'h7 : cnt - 3'(cnt != 3'h0);
    end
  end
endmodule : sysmon_conv_model

// ---- verification/sysmon_ctrl_props.sv ----
// Port assertions for the converter control block
`timescale 1ns/10ps
module sysmon_ctrl_chk (
  input wire logic i_mclk, i_rst, i_wb_cyc, i_wb_stb, o_wb_ack, i_drp_en, o_drp_rdy,
  input wire logic i_conv_valid, o_conversion_done, o_sequence_done,
  input wire logic o_cfg_shutdown, o_global_output_hold, o_startup_active
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // Hold must cover the whole shutdown, which is short
  sequence shut_end; ##[2:8] !o_cfg_shutdown; endsequence
  sequence restart; ##[0:2] o_startup_active; endsequence
  chk_ack_next: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("ack late");
  chk_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack long");
  chk_rdy_next: assert property (i_drp_en |=> o_drp_rdy) else $error("rdy late");
  chk_rdy_cause: assert property (!i_drp_en |=> !o_drp_rdy) else $error("rdy extra");
  chk_eoc_cause: assert property (o_conversion_done |-> $past(i_conv_valid))
    else $error("eoc early");
  chk_eos_eoc: assert property (o_sequence_done |-> o_conversion_done) else $error("eos");
  chk_shut_hold: assert property (
    $rose(o_cfg_shutdown) |-> o_global_output_hold throughout shut_end) else $error("hold");
  chk_hold_restart: assert property ($fell(o_global_output_hold) |-> restart)
    else $error("no restart");
endmodule : sysmon_ctrl_chk
bind sysmon_ctrl sysmon_ctrl_chk sysmon_ctrl_chk_i (.i_mclk, .i_rst, .i_wb_cyc, .i_wb_stb,
  .o_wb_ack, .i_drp_en, .o_drp_rdy, .i_conv_valid, .o_conversion_done, .o_sequence_done,
  .o_cfg_shutdown, .o_global_output_hold, .o_startup_active);

// ---- verification/test_system_monitor_adc_control.sv ----
// Self-checking bench for the converter control block
`timescale 1ns/10ps
module test_system_monitor_adc_control;
  import sysmon_pkg::*;
  logic i_mclk = 0, i_rst = 1, i_config_done = 1, i_block_used = 1, i_wb_cyc = 0, i_wb_stb = 0;
  logic i_wb_we = 0, i_drp_en = 0, i_drp_we = 0, i_jtag_rd_en = 0, o_wb_ack, o_drp_rdy, o_jtag_rdy;
  logic o_conv_start, i_conv_valid, o_conversion_done, o_sequence_done, o_overtemp_alarm, o_irq;
  logic o_cfg_shutdown, o_global_output_hold, o_startup_active;
  logic [31:0] i_wb_adr = 0, i_wb_dat = 0, o_wb_dat, q;
  logic [15:0] i_drp_di = 0, o_drp_do, o_jtag_data;
  logic [11:0] i_conv_data, temp = 12'h400;
  logic [6:0]  i_drp_addr = 0, i_jtag_addr = 0;
  logic [4:0]  o_conv_chan;
  logic [3:0]  i_wb_sel = 4'h3;
  logic [2:0]  o_alarm;
  int miscompares = 0, n_compared = 0;
  always #2 i_mclk = ~i_mclk;
  // Short shutdown and start-up keep over-temperature runs brief
  sysmon_ctrl #(.SHUTDOWN_CYCLES(4), .STARTUP_CYCLES(4)) sysmon_ctrl_i (.*);
  sysmon_conv_model sysmon_conv_model_i (.i_mclk, .i_rst, .i_start(o_conv_start),
    .i_chan(o_conv_chan), .i_temp(temp), .o_valid(i_conv_valid), .o_data(i_conv_data));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  // Levels are looked at mid-cycle, where they have settled
  task automatic wait_for(ref logic s, input logic v);
    for (int n = 0; n < 400 && s !== v; n++) @(negedge i_mclk);
    if (s !== v) begin
      miscompares++;
      end_sim();
    end
  endtask : wait_for
  task automatic wb(input logic w, input logic [6:0] idx, input logic [15:0] d);
    @(posedge i_mclk);
    {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat} <= {2'b11, w, 23'h0, idx, 2'h0, 16'h0, d};
    wait_for(o_wb_ack, 1'b1);
    @(posedge i_mclk);
    q = o_wb_dat;
    {i_wb_cyc, i_wb_stb} <= 2'b00;
    @(negedge i_mclk);
  endtask : wb
  task automatic dynamic_reconfig_port(input logic w, input logic [6:0] idx, input logic [15:0] d);
    @(posedge i_mclk);
    {i_drp_en, i_drp_we, i_drp_addr, i_drp_di} <= {1'b1, w, idx, d};
    @(posedge i_mclk);
    i_drp_en <= 1'b0;
    @(negedge i_mclk);
    chk(32'(o_drp_rdy), 32'h1);
    q = {16'h0, o_drp_do};
  endtask : dynamic_reconfig_port
  task automatic t_reset_vals;
    wb(0, REG_MIN0, 0);
    chk(q, 32'hFFFF);
    wb(0, REG_CFG, 0);
    chk(q, 32'h1);
    wb(0, 7'h7F, 0);
    chk(q, 32'h0);
  endtask : t_reset_vals
  task automatic t_results;
    wait_for(o_sequence_done, 1'b1);
    for (int c = 1; c < 4; c++) begin
      wb(0, REG_RESULT0 + 7'(c), 0);
      chk(q, {16'h0, 12'h200 + 12'(c), 4'h0});
    end
    wb(0, REG_RESULT0, 0);
    chk(q, 32'h4000);
    wb(1, REG_RESULT0 + 7'h3, 16'h5555);
    wb(0, REG_RESULT0 + 7'h3, 0);
    chk(q, 32'h2030);
  endtask : t_results
  task automatic t_drp;
    dynamic_reconfig_port(1, REG_UPPER0, 16'h8000);
    dynamic_reconfig_port(0, REG_UPPER0, 0);
    chk(q, 32'h8000);
    i_config_done <= 0;
    dynamic_reconfig_port(1, REG_UPPER0, 16'h1111);
    dynamic_reconfig_port(0, REG_UPPER0, 0);
    chk(q, 32'h8000);
    i_config_done <= 1;
    @(posedge i_mclk);
    {i_jtag_rd_en, i_jtag_addr} <= {1'b1, REG_RESULT0 + 7'h1};
    @(posedge i_mclk);
    i_jtag_rd_en <= 0;
    @(negedge i_mclk);
    chk({o_jtag_rdy, o_jtag_data}, 32'h12010);
  endtask : t_drp
  task automatic t_irq;
    wb(1, REG_INT_MASK, 16'h1);
    chk(32'(o_irq), 32'h1);
    wb(1, REG_INT_MASK, 0);
    chk(32'(o_irq), 32'h0);
  endtask : t_irq
  task automatic t_ot;
    wb(1, REG_CFG, 16'h9);
    temp = 12'hC00;
    wait_for(o_overtemp_alarm, 1'b1);
    repeat (2) @(negedge i_mclk);
    chk({o_alarm[0], o_global_output_hold}, 32'h3);
    temp = 12'hA00;
    wait_for(o_sequence_done, 1'b1);
    @(negedge i_mclk);
    wait_for(o_sequence_done, 1'b1);
    chk(32'(o_overtemp_alarm), 32'h1);
    temp = 12'h800;
    wait_for(o_overtemp_alarm, 1'b0);
    wait_for(o_global_output_hold, 1'b0);
  endtask : t_ot
  // Two sequence ends guarantee a fresh sample after the bipolar change; default mode waits for one
  task automatic t_mode;
    wb(1, REG_BIP_LO, 16'h8);
    wait_for(o_sequence_done, 1'b1);
    @(negedge i_mclk);
    wait_for(o_sequence_done, 1'b1);
    wb(0, REG_RESULT0 + 7'h3, 0);
    chk(q, 32'hA030);
    i_block_used <= 0;
    wb(1, REG_CFG, 16'h0);
    wb(0, REG_CFG, 0);
    chk(q, 32'h9);
    wait_for(o_sequence_done, 1'b1);
    wb(0, REG_FLAGS, 0);
    chk(q & 32'hDF, 32'h40);
  endtask : t_mode
  initial begin
    repeat (12) @(posedge i_mclk);
    i_rst <= 0;
    t_reset_vals();
    t_results();
    t_drp();
    t_irq();
    t_ot();
    t_mode();
    end_sim();
  end
  initial begin
    repeat (50000) @(posedge i_mclk);
    miscompares++;
    end_sim();
  end
endmodule : test_system_monitor_adc_control
